// [sarcv_pkg.sv]
/*
 * Shared constants for the converter control link.
 * Assumes a single 100 MHz system clock on both ends.
 */
package sarcv_pkg;
	localparam int unsigned SARCV_CLK_NS        = 10;
	localparam int unsigned SARCV_DATA_W        = 16;
	localparam int unsigned SARCV_BYTE_W        = 8;
	localparam int unsigned SARCV_START_MIN_NS  = 40;
	localparam int unsigned SARCV_SETUP_NS      = 10;
	localparam int unsigned SARCV_RELEASE_MAX_NS = 1000;
	localparam int unsigned SARCV_CONV_NS       = 2300;
	localparam int unsigned SARCV_ACQ_NS        = 1000;
	localparam int unsigned SARCV_START_CYC     = (SARCV_START_MIN_NS + SARCV_CLK_NS - 1) / SARCV_CLK_NS;
	localparam int unsigned SARCV_SETUP_CYC     = (SARCV_SETUP_NS + SARCV_CLK_NS - 1) / SARCV_CLK_NS;
	localparam int unsigned SARCV_CONV_CYC      = SARCV_CONV_NS / SARCV_CLK_NS;
	localparam int unsigned SARCV_ACQ_CYC       = (SARCV_ACQ_NS + SARCV_CLK_NS - 1) / SARCV_CLK_NS;
	localparam logic [15:0] SARCV_CODE_POS_FS   = 16'h7FFF;
	localparam logic [15:0] SARCV_CODE_NEG_ONE  = 16'hFFFF;
	localparam logic [15:0] SARCV_RESULT_RST    = 16'h0000;
	localparam int unsigned SARCV_HI_LSB        = 8;
endpackage

// [sarcv_if.sv]
/*
 * Pin bundle between the converter and its host.
 * Assumes the host resolves the shared data bus from the enable.
 */
interface sarcv_if;
	logic        select_n;          // chip select, active low
	logic        read_not_convert;  // high read, low convert
	logic        byte_swap;         // swap byte lanes
	logic        busy_n;            // low while converting
	logic [15:0] data_o;            // converter data drive
	logic        data_oe;           // converter drives data bus
	modport device (input select_n, input read_not_convert, input byte_swap,
		output busy_n, output data_o, output data_oe);
	modport host (output select_n, output read_not_convert, output byte_swap,
		input busy_n, input data_o, input data_oe);
endinterface

// [sarcv_fifo.sv]
/*
 * Parameterised synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; depth is a power of two.
 */
module sarcv_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_sys,   // system clock
	input  wire logic             arst_n,    // async reset
	input  wire logic             in_valid,  // write offer
	output logic                  in_ready,  // room available
	input  wire logic [WIDTH-1:0] in_data,   // write word
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // reader takes
	output logic [WIDTH-1:0]      out_data   // head word
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
	logic             push, pop;

	always_comb begin
		push = in_valid && in_ready;
		pop  = out_valid && out_ready;
		wr_d = wr_q + (AW+1)'(push);
		rd_d = rd_q + (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	assign in_ready  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem[rd_q[AW-1:0]];
endmodule

// [sarcv_device.sv]
/*
 * Converter end: start detection, conversion sequencer, result latch and
 * three-state data port.
 * Assumes the control pins are asynchronous to clk_sys; the analog
 * comparator decision arrives as a plain input sampled per bit step.
 */
// Operation
// - select and read/convert low 40ns starts
// - starts ignored while converting
// - busy low throughout conversion
// - mode one: read/convert falling edge starts
// - busy rises after result latched; busy_n and result_q load on the same edge, data_o a cycle later
// - data hi-z while read/convert low
// - host releases controls within 1us
// - mode two: read/convert low before select
// - select low pulses at least 40ns
// - mode two: busy falls at select
// - select low after busy reads data
// - conversion takes about 2.3us
// - acquisition plus conversion gives 250ksps; constants set 1us acquisition plus 2.3us conversion, 3.3us
// - positive full scale code 7FFF
// - zero crossing wraps FFFF to 0000
// - results two's complement, word or bytes
// - byte_swap moves low byte upward
// - select ORed with read/convert
// - controls high when busy rises; in mode one the host keeps select low and only read/convert is high
module sarcv_device
	import sarcv_pkg::*;
#(
	parameter int unsigned CONV_CYC  = SARCV_CONV_CYC,
	parameter int unsigned START_CYC = SARCV_START_CYC
) (
	input  wire logic              clk_sys,      // system clock
	input  wire logic              arst_n,       // async reset
	sarcv_if.device                pins,         // link pins
	input  wire logic              comp_above,   // comparator: input above trial
	output logic [SARCV_DATA_W-1:0] result_q,    // last result word
	output logic                   done_q        // pulse: new result
);
	localparam int unsigned CW = $clog2(CONV_CYC + 1);
	localparam int unsigned SW = $clog2(START_CYC + 1);
	localparam int unsigned STEP = CONV_CYC / SARCV_DATA_W;

	typedef enum logic [1:0] {SARCV_IDLE, SARCV_CONV, SARCV_LOAD} sarcv_state_t;

	logic [1:0] cs_sync_q, rc_sync_q, bs_sync_q;
	logic       start_low, start_low_q;
	sarcv_state_t state_q, state_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [SW-1:0] low_q, low_d;
	logic [SARCV_DATA_W-1:0] approximation_register_q, approximation_register_d;
	logic [4:0]  bit_q, bit_d;
	logic [SARCV_DATA_W-1:0] result_d;
	logic        busy_n_q, busy_n_d, done_d;
	logic [SARCV_DATA_W-1:0] data_q, data_d;
	logic        oe_q, oe_d;

	// two-stage synchronisers; only the second stage feeds logic
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cs_sync_q <= 2'h3;
			rc_sync_q <= 2'h3;
			bs_sync_q <= 2'h0;
		end else begin
			cs_sync_q <= {cs_sync_q[0], pins.select_n};
			rc_sync_q <= {rc_sync_q[0], pins.read_not_convert};
			bs_sync_q <= {bs_sync_q[0], pins.byte_swap};
		end
	end

	// internal OR of the two controls: low only when both are low
	assign start_low = !(cs_sync_q[1] | rc_sync_q[1]);

	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		low_d    = low_q;
		approximation_register_d = approximation_register_q;
		bit_d    = bit_q;
		result_d = result_q;
		busy_n_d = busy_n_q;
		done_d   = 1'b0;
		unique case (state_q)
			SARCV_IDLE: begin
				// combined low held for the minimum start width
				if (start_low && low_q != SW'(START_CYC)) begin
					low_d = low_q + SW'(1);
				end else if (!start_low) begin
					low_d = '0;
				end
				// combined low held for START_CYC sampled cycles, either pin last
				if (start_low && start_low_q && low_q == SW'(START_CYC - 1)) begin
					state_d  = SARCV_CONV;
					busy_n_d = 1'b0;
					cnt_d    = '0;
					bit_d    = 5'(SARCV_DATA_W - 1);
					approximation_register_d = '0;
				end
			end
			SARCV_CONV: begin
				cnt_d = cnt_q + CW'(1);
				// bit decisions msb first, two's complement msb inverted
				if (cnt_q == CW'((SARCV_DATA_W - 1 - bit_q) * STEP + STEP - 1)) begin
					approximation_register_d[bit_q[3:0]] =
						(bit_q == 5'(SARCV_DATA_W - 1)) ? !comp_above : comp_above;
					if (bit_q != 5'h0) begin
						bit_d = bit_q - 5'h1;
					end
				end
				if (cnt_q == CW'(CONV_CYC - 1)) begin
					state_d = SARCV_LOAD;
				end
			end
			SARCV_LOAD: begin
				result_d = approximation_register_q;
				done_d   = 1'b1;
				busy_n_d = 1'b1;
				low_d    = '0;
				state_d  = SARCV_IDLE;
			end
			default: state_d = SARCV_IDLE;
		endcase
	end

	// output port: drive only when selected and reading
	always_comb begin
		oe_d   = !cs_sync_q[1] && rc_sync_q[1];
		data_d = bs_sync_q[1] ? {result_q[SARCV_BYTE_W-1:0], result_q[SARCV_DATA_W-1:SARCV_HI_LSB]}
		                      : result_q;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q  <= SARCV_IDLE;
			cnt_q    <= '0;
			low_q    <= '0;
			start_low_q <= 1'b0;
			approximation_register_q <= '0;
			bit_q    <= '0;
			result_q <= SARCV_RESULT_RST;
			busy_n_q <= 1'b1;
			done_q   <= 1'b0;
			data_q   <= '0;
			oe_q     <= 1'b0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			low_q    <= low_d;
			start_low_q <= start_low;
			approximation_register_q <= approximation_register_d;
			bit_q    <= bit_d;
			result_q <= result_d;
			busy_n_q <= busy_n_d;
			done_q   <= done_d;
			data_q   <= data_d;
			oe_q     <= oe_d;
		end
	end

	assign pins.busy_n  = busy_n_q;
	assign pins.data_o  = data_q;
	assign pins.data_oe = oe_q;
endmodule

// [sarcv_host.sv]
/*
 * Host end: issues conversions in either mode, reads results, pushes
 * them into a FIFO drained by user logic.
 * Assumes busy and data arrive asynchronously from the converter pins.
 */
module sarcv_host
	import sarcv_pkg::*;
#(
	parameter int unsigned DEPTH = 8,
	parameter int unsigned ACQ_CYC = SARCV_ACQ_CYC
) (
	input  wire logic                    clk_sys,   // system clock
	input  wire logic                    arst_n,    // async reset
	sarcv_if.host                        pins,      // link pins
	input  wire logic                    start,     // pulse: convert once
	input  wire logic                    mode_cs,   // 0 mode one, 1 mode two
	input  wire logic                    lane_swap, // read low byte on upper lanes
	output logic                         idle_q,    // ready for start
	output logic                         out_valid, // result available
	input  wire logic                    out_ready, // user takes result
	output logic [SARCV_DATA_W-1:0]      out_data   // result word
);
	typedef enum logic [2:0] {SH_IDLE, SH_SETUP, SH_START, SH_WAIT_LO, SH_WAIT_HI,
		SH_READ, SH_PUSH, SH_ACQ} sarcv_host_state_t;
	localparam int unsigned CW = 8;

	sarcv_host_state_t st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic cs_q, cs_d, rc_q, rc_d, mode_q, mode_d, idle_d;
	logic swap_q, swap_d;
	logic [1:0] busy_sync_q;
	logic [SARCV_DATA_W-1:0] d1_q, d2_q;
	logic push, push_ready;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			busy_sync_q <= 2'h3;
			d1_q <= '0;
			d2_q <= '0;
		end else begin
			busy_sync_q <= {busy_sync_q[0], pins.busy_n};
			d1_q <= pins.data_oe ? pins.data_o : 16'h0000;
			d2_q <= d1_q;
		end
	end

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + CW'(1);
		cs_d = cs_q;
		rc_d = rc_q;
		mode_d = mode_q;
		swap_d = swap_q;
		idle_d = 1'b0;
		push = 1'b0;
		unique case (st_q)
			SH_IDLE: begin
				idle_d = 1'b1;
				cs_d = 1'b1;
				rc_d = 1'b1;
				if (start) begin
					mode_d = mode_cs;
					swap_d = lane_swap;
					idle_d = 1'b0;
					cnt_d = '0;
					// lower the line that does not start the conversion first
					rc_d = !mode_cs;
					cs_d = mode_cs;
					st_d = SH_SETUP;
				end
			end
			SH_SETUP: if (cnt_q == CW'(SARCV_SETUP_CYC)) begin
				cs_d = 1'b0;
				rc_d = 1'b0;
				cnt_d = '0;
				st_d = SH_START;
			end
			SH_START: if (cnt_q == CW'(SARCV_START_CYC + 4)) begin
				rc_d = 1'b1;
				// mode one keeps select low through the read
				cs_d = mode_q;
				st_d = SH_WAIT_LO;
			end
			SH_WAIT_LO: if (!busy_sync_q[1]) st_d = SH_WAIT_HI;
			SH_WAIT_HI: if (busy_sync_q[1]) begin
				cnt_d = '0;
				cs_d = 1'b0;
				st_d = SH_READ;
			end
			SH_READ: if (cnt_q == CW'(SARCV_START_CYC + 4)) begin
				st_d = SH_PUSH;
			end
			SH_PUSH: if (push_ready) begin
				push = 1'b1;
				cs_d = 1'b1;
				cnt_d = '0;
				st_d = SH_ACQ;
			end else begin
				cnt_d = cnt_q;
			end
			SH_ACQ: if (cnt_q == CW'(ACQ_CYC - 1)) st_d = SH_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= SH_IDLE;
			cnt_q <= '0;
			cs_q <= 1'b1;
			rc_q <= 1'b1;
			mode_q <= 1'b0;
			swap_q <= 1'b0;
			idle_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			cs_q <= cs_d;
			rc_q <= rc_d;
			mode_q <= mode_d;
			swap_q <= swap_d;
			idle_q <= idle_d;
		end
	end

	assign pins.select_n = cs_q;
	assign pins.read_not_convert = rc_q;
	assign pins.byte_swap = swap_q;

	sarcv_fifo #(.WIDTH(SARCV_DATA_W), .DEPTH(DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (push),
		.in_ready  (push_ready),
		.in_data   (d2_q),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_data)
	);
endmodule

// [sarcv_link_properties.sv]
/*
 * Assertions on the pins between converter and host.
 * Assumes instantiation beside the link interface, one clock domain.
 */
module sarcv_link_properties #(
	parameter int unsigned CONV_CYC = 230
) (
	input wire logic        clk_sys,          // system clock
	input wire logic        arst_n,           // async reset
	input wire logic        select_n,         // chip select
	input wire logic        read_not_convert, // read or convert
	input wire logic        byte_swap,        // lane swap
	input wire logic        busy_n,           // low while converting
	input wire logic [15:0] data_o,           // device data
	input wire logic        data_oe           // device drives bus
);
	logic [15:0] low_cnt_q;
	logic [15:0] low_cnt_d;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// length of the current busy low stretch
	always_comb begin
		low_cnt_d = busy_n ? 16'h0000 : low_cnt_q + 16'h0001;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt_q <= 16'h0000;
		end else begin
			low_cnt_q <= low_cnt_d;
		end
	end

	hiz_convert_a: assert property ((!read_not_convert)[*4] |-> !data_oe)
		else $error("data driven while converting");
	hiz_deselect_a: assert property (select_n[*4] |-> !data_oe)
		else $error("data driven while deselected");
	drive_read_a: assert property ((!select_n && read_not_convert)[*4] |-> data_oe)
		else $error("data not driven during read");
	busy_start_a: assert property ($fell(busy_n) |-> $past(!select_n && !read_not_convert, 3))
		else $error("busy fell without a start request");
	conv_len_a: assert property ($rose(busy_n) |-> low_cnt_q >= CONV_CYC - 1 && low_cnt_q <= CONV_CYC + 3)
		else $error("conversion length wrong");
	busy_rise_a: assert property ($rose(busy_n) |-> select_n || read_not_convert)
		else $error("controls low when busy rose");
	release_window_a: assert property ($fell(busy_n) |-> ##[1:100] read_not_convert)
		else $error("convert request held too long");
	setup_before_a: assert property ($fell(select_n) && !read_not_convert
		|-> $past(!read_not_convert))
		else $error("convert not set up before select");
	pulse_width_a: assert property ($fell(select_n) |-> (!select_n)[*4])
		else $error("select pulse too short");
	data_steady_a: assert property (data_oe && $past(data_oe) && $stable(byte_swap)
		&& $past(busy_n) == $past(busy_n, 2) |-> $stable(data_o))
		else $error("read data changed while driven");
endmodule

// [sar_adc_convert_read_control_tb.sv]
/*
 * Testbench joining converter and host through the link interface.
 * Assumes shortened conversion and acquisition counts.
 */
module sar_adc_convert_read_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sarcv_pkg::*;

	localparam int unsigned CONV = 32;
	typedef struct packed {
		logic        mode;
		logic        swap;
		logic        comp;
		logic [15:0] exp;
		logic [15:0] lanes;
	} sarcv_row_t;
	localparam sarcv_row_t ROWS [4] = '{
		'{1'b0, 1'b0, 1'b1, SARCV_CODE_POS_FS, SARCV_CODE_POS_FS},
		'{1'b0, 1'b1, 1'b0, 16'h8000, 16'h0080},
		'{1'b1, 1'b1, 1'b1, SARCV_CODE_POS_FS, 16'hFF7F},
		'{1'b1, 1'b0, 1'b0, 16'h8000, 16'h8000}};

	logic        clk_sys, arst_n, start, mode_cs, out_ready, comp_above;
	logic        lane_swap;
	logic        idle_q, out_valid, done_q;
	logic [15:0] out_data, result_q;
	int          num_errors, n_compared;

	sarcv_if link ();
	sarcv_device #(.CONV_CYC(CONV)) sarcv_device_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.pins(link.device), .comp_above(comp_above), .result_q(result_q), .done_q(done_q));
	sarcv_host #(.DEPTH(8), .ACQ_CYC(8)) sarcv_host_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.pins(link.host), .start(start), .mode_cs(mode_cs), .lane_swap(lane_swap), .idle_q(idle_q),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
	sarcv_link_properties #(.CONV_CYC(CONV)) sarcv_link_properties_inst (.clk_sys(clk_sys),
		.arst_n(arst_n), .select_n(link.select_n), .read_not_convert(link.read_not_convert),
		.byte_swap(link.byte_swap), .busy_n(link.busy_n), .data_o(link.data_o),
		.data_oe(link.data_oe));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_hi(ref logic sig, input string what);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (sig !== 1'b1 && n < 2000);
		check(what, {15'h0000, sig}, 16'h0001);
	endtask

	task automatic convert(input logic mode, input logic swap, input logic comp);
		// only touch the comparator once the previous conversion is over
		wait_hi(idle_q, "idle_q");
		mode_cs <= mode;
		lane_swap <= swap;
		comp_above <= comp;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
	endtask

	task automatic pop(input logic [15:0] exp);
		wait_hi(out_valid, "out_valid");
		check("out_data", out_data, exp);
		out_ready <= 1'b1;
		@(posedge clk_sys);
		out_ready <= 1'b0;
	endtask

	task automatic results();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// cut a hang short
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		results();
	end

	initial begin
		arst_n = 1'b0;
		start = 1'b0;
		mode_cs = 1'b0;
		lane_swap = 1'b0;
		out_ready = 1'b0;
		comp_above = 1'b0;
		num_errors = 0;
		n_compared = 0;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		foreach (ROWS[i]) begin
			convert(ROWS[i].mode, ROWS[i].swap, ROWS[i].comp);
			wait_hi(done_q, "done_q");
			check("busy_n", {15'h0000, link.busy_n}, 16'h0001);
			check("result_q", result_q, ROWS[i].exp);
			pop(ROWS[i].lanes);
		end
		// overfill the buffer with the reader stalled, then drain it
		for (int i = 0; i < 9; i++)
			convert(1'b1, 1'b0, i[0]);
		for (int i = 0; i < 9; i++)
			pop(i[0] ? SARCV_CODE_POS_FS : 16'h8000);
		@(posedge clk_sys);
		check("out_valid", {15'h0000, out_valid}, 16'h0000);
		// reset in mid conversion
		convert(1'b0, 1'b0, 1'b1);
		repeat (20) @(posedge clk_sys);
		check("busy_n", {15'h0000, link.busy_n}, 16'h0000);
		arst_n <= 1'b0;
		@(posedge clk_sys);
		check("busy_n", {15'h0000, link.busy_n}, 16'h0001);
		check("data_oe", {15'h0000, link.data_oe}, 16'h0000);
		check("select_n", {15'h0000, link.select_n}, 16'h0001);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		convert(1'b0, 1'b0, 1'b0);
		pop(16'h8000);
		results();
	end
endmodule
